// ---- spcs_pkg.sv ----
/*
  Constants for the special-function-register page context stack:
  register addresses, reset values, the control field position and
  the shared address decode function.
  Assumes an 8-bit special-function-register address and data bus.
*/
package spcs_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'h84;
  localparam logic [7:0] ADDR_STACK_SECOND = 8'h85;
  localparam logic [7:0] ADDR_STACK_THIRD = 8'h86;
  localparam logic [7:0] ADDR_PAGING_CTRL = 8'h96;
  // the control register is the only one tied to a single page
  localparam logic [7:0] PAGE_PAGING_CTRL = 8'h0f;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
  localparam logic [7:0] RST_STACK_SECOND = 8'h00;
  localparam logic [7:0] RST_STACK_THIRD = 8'h00;
  localparam logic RST_AUTO_PAGING = 1'b1;
  localparam int unsigned BIT_AUTO_PAGING = 0;
  // bits 7..1 of the control register are reserved and read as zero
  localparam logic [6:0] CTRL_RSVD_READ = 7'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  typedef logic [7:0] spcs_byte_t;

  // ----------------------------------------------------------------
  // address decode, shared by write and read paths
  // ----------------------------------------------------------------
  function automatic logic spcs_hit(input logic [7:0] addr, input logic [7:0] page,
                                    input logic [7:0] reg_addr, input logic all_pages,
                                    input logic [7:0] reg_page);
    return (addr == reg_addr) && (all_pages || (page == reg_page));
  endfunction

endpackage

// ---- spcs_rst_sync.sv ----
/*
  Reset release synchroniser for the page context stack.
  Assumes rst_n is asynchronous and active low; assertion is
  immediate, release is taken through two core_clk flip-flops.
*/
`timescale 1ns/1ps
module spcs_rst_sync (
  // clock and raw reset
  input wire logic core_clk,
  input wire logic rst_n,
  // synchronised reset
  output logic rst_sync_n
);

  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  // ----------------------------------------------------------------
  // release path
  // ----------------------------------------------------------------
  // next values: a one marches in; the first stage feeds only the second
  always_comb begin
    meta_nxt = 1'b1;
    sync_nxt = meta_r;
  end

  // not gated by the clock enable, so reset always releases
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      rst_sync_n <= sync_nxt;
    end
  end

endmodule

// ---- spcs_sfr_port.sv ----
/*
  Register-bus port of the page context stack: decodes writes to the
  three stack bytes and the paging control register, and returns read
  data one cycle after a read strobe.
  Assumes bus strobes come from logic on core_clk, one cycle each.
*/
`timescale 1ns/1ps
module spcs_sfr_port (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_sync_n,
  input wire logic clk_en,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  // current register contents
  input wire logic [7:0] page_select,
  input wire logic [7:0] stack_second,
  input wire logic [7:0] stack_third,
  input wire logic auto_paging_enable,
  // decoded write strobes
  output logic wr_page,
  output logic wr_second,
  output logic wr_third,
  output logic wr_ctrl,
  // read answer
  output logic [7:0] sfr_rdata,
  output logic sfr_rdata_valid
);

  logic hit_page;
  logic hit_second;
  logic hit_third;
  logic hit_ctrl;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // stack bytes answer on every page, control only on its own page
  always_comb begin
    hit_page = spcs_pkg::spcs_hit(sfr_addr, page_select, spcs_pkg::ADDR_PAGE_SELECT,
                                  1'b1, spcs_pkg::PAGE_PAGING_CTRL);
    hit_second = spcs_pkg::spcs_hit(sfr_addr, page_select, spcs_pkg::ADDR_STACK_SECOND,
                                    1'b1, spcs_pkg::PAGE_PAGING_CTRL);
    hit_third = spcs_pkg::spcs_hit(sfr_addr, page_select, spcs_pkg::ADDR_STACK_THIRD,
                                   1'b1, spcs_pkg::PAGE_PAGING_CTRL);
    hit_ctrl = spcs_pkg::spcs_hit(sfr_addr, page_select, spcs_pkg::ADDR_PAGING_CTRL,
                                  1'b0, spcs_pkg::PAGE_PAGING_CTRL);
    wr_page = sfr_wr && hit_page;
    wr_second = sfr_wr && hit_second;
    wr_third = sfr_wr && hit_third;
    wr_ctrl = sfr_wr && hit_ctrl;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // reads have no side effect; unmapped addresses leave valid low
  always_comb begin
    rdata_nxt = spcs_pkg::DATA_ZERO;
    rvalid_nxt = 1'b0;
    if (sfr_rd) begin
      rvalid_nxt = hit_page || hit_second || hit_third || hit_ctrl;
      if (hit_page) begin
        rdata_nxt = page_select;
      end else if (hit_second) begin
        rdata_nxt = stack_second;
      end else if (hit_third) begin
        rdata_nxt = stack_third;
      end else if (hit_ctrl) begin
        rdata_nxt = {spcs_pkg::CTRL_RSVD_READ, auto_paging_enable};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= spcs_pkg::DATA_ZERO;
      sfr_rdata_valid <= 1'b0;
    end else if (clk_en) begin
      sfr_rdata <= rdata_nxt;
      sfr_rdata_valid <= rvalid_nxt;
    end
  end

endmodule

// ---- spcs_page_stack.sv ----
/*
  Three-entry special-function-register page context stack. The top
  entry is the live page select; interrupt entry pushes, interrupt
  return pops, and software reaches every entry over the register bus.
  Assumes the interrupt sequencer and bus run on core_clk and give
  one-cycle strobes; rst_n may arrive asynchronously.
*/
// Notes on behaviour
// - page context lives in three entries: page select, second, third.
// - software access to second or third entry changes only that entry.
// - only interrupt entry pushes and only interrupt return pops.
// - writing the second entry sets the page restored on next return.
// - reading the second entry gives the page restored on next return.
// - writing the third entry sets what the second holds after next return.
// - reading the third entry gives the bottom entry with no side effect.
// - second entry answers at 0x85 on every page.
// - third entry answers at 0x86 on every page.
// - push: second to third, page to second, interrupt page to page.
// - pop: second to page select, third to second.
// - auto paging off stops page switching and stack motion; resets on.
// - page select at 0x84 on all pages, resets zero, writes never shift.
`timescale 1ns/1ps
module spcs_page_stack (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // interrupt sequencer
  input wire logic irq_vector,
  input wire logic [7:0] irq_page,
  input wire logic irq_return,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_rdata_valid,
  // live state
  output logic [7:0] page_select,
  output logic auto_paging_enable
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rst_sync_n;
  logic wr_page;
  logic wr_second;
  logic wr_third;
  logic wr_ctrl;
  logic push_go;
  logic pop_go;
  spcs_pkg::spcs_byte_t page_r;
  spcs_pkg::spcs_byte_t page_nxt;
  spcs_pkg::spcs_byte_t second_r;
  spcs_pkg::spcs_byte_t second_nxt;
  spcs_pkg::spcs_byte_t third_r;
  spcs_pkg::spcs_byte_t third_nxt;
  logic auto_en_r;
  logic auto_en_nxt;

  // ----------------------------------------------------------------
  // reset release and register port
  // ----------------------------------------------------------------
  spcs_rst_sync u_rst_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  spcs_sfr_port u_sfr_port (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .clk_en(clk_en),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .page_select(page_r),
    .stack_second(second_r),
    .stack_third(third_r),
    .auto_paging_enable(auto_en_r),
    .wr_page(wr_page),
    .wr_second(wr_second),
    .wr_third(wr_third),
    .wr_ctrl(wr_ctrl),
    .sfr_rdata(sfr_rdata),
    .sfr_rdata_valid(sfr_rdata_valid)
  );

  // ----------------------------------------------------------------
  // stack motion
  // ----------------------------------------------------------------
  // a push and a return together: the push wins and the return is lost,
  // since the sequencer is not expected to issue both at once
  always_comb begin
    push_go = auto_en_r && irq_vector;
    pop_go = auto_en_r && irq_return && !irq_vector;
  end

  // next values; hardware shifts are tested first so they win over
  // a stack-entry write landing in the same cycle; a control write still lands
  always_comb begin
    page_nxt = page_r;
    second_nxt = second_r;
    third_nxt = third_r;
    auto_en_nxt = auto_en_r;
    if (push_go) begin
      third_nxt = second_r;
      second_nxt = page_r;
      page_nxt = irq_page;
    end else if (pop_go) begin
      page_nxt = second_r;
      second_nxt = third_r;
    end else begin
      // software writes touch only their own entry
      if (wr_page) begin
        page_nxt = sfr_wdata;
      end
      if (wr_second) begin
        second_nxt = sfr_wdata;
      end
      if (wr_third) begin
        third_nxt = sfr_wdata;
      end
    end
    if (wr_ctrl) begin
      auto_en_nxt = sfr_wdata[spcs_pkg::BIT_AUTO_PAGING];
    end
  end

  // frozen entirely while clk_en is low
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      page_r <= spcs_pkg::RST_PAGE_SELECT;
      second_r <= spcs_pkg::RST_STACK_SECOND;
      third_r <= spcs_pkg::RST_STACK_THIRD;
      auto_en_r <= spcs_pkg::RST_AUTO_PAGING;
    end else if (clk_en) begin
      page_r <= page_nxt;
      second_r <= second_nxt;
      third_r <= third_nxt;
      auto_en_r <= auto_en_nxt;
    end
  end

  // outputs come straight from the flip-flops
  assign page_select = page_r;
  assign auto_paging_enable = auto_en_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_sync_n);

  // one accepted push, one accepted pop, and an idle cycle
  sequence s_push;
    clk_en && push_go;
  endsequence

  sequence s_pop_clean;
    clk_en && pop_go;
  endsequence

  sequence s_quiet;
    clk_en && !irq_vector && !irq_return && !sfr_wr;
  endsequence

  property p_push;
    s_push |=> (page_r == $past(irq_page)) && (second_r == $past(page_r)) &&
      (third_r == $past(second_r));
  endproperty
  a_push: assert property (p_push)
    else $error("push did not shift the page stack");

  property p_pop;
    s_pop_clean |=> (page_r == $past(second_r)) && (second_r == $past(third_r));
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop did not restore the page stack");

  // a push followed by a pop brings back the page from before the push
  property p_push_pop;
    s_push ##1 s_pop_clean |=> (page_r == $past(page_r, 2)) &&
      (second_r == $past(second_r, 2));
  endproperty
  a_push_pop: assert property (p_push_pop)
    else $error("push then pop lost the page context");

  property p_quiet;
    s_quiet |=> $stable(page_r) && $stable(second_r) && $stable(third_r);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("stack moved without an interrupt event");

  property p_disabled;
    clk_en && !auto_en_r && !sfr_wr |=> $stable(page_r) && $stable(second_r) &&
      $stable(third_r);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("stack moved with auto paging disabled");

  property p_wr_second;
    clk_en && wr_second && !push_go && !pop_go |=> (second_r == $past(sfr_wdata)) &&
      $stable(page_r) && $stable(third_r);
  endproperty
  a_wr_second: assert property (p_wr_second)
    else $error("second entry write wrong or disturbed other entries");

  property p_wr_third;
    clk_en && wr_third && !push_go && !pop_go |=> (third_r == $past(sfr_wdata)) &&
      $stable(page_r) && $stable(second_r);
  endproperty
  a_wr_third: assert property (p_wr_third)
    else $error("third entry write wrong or disturbed other entries");

  property p_wr_page;
    clk_en && wr_page && !push_go && !pop_go |=> (page_r == $past(sfr_wdata)) &&
      $stable(second_r) && $stable(third_r);
  endproperty
  a_wr_page: assert property (p_wr_page)
    else $error("page select write wrong or shifted the stack");

  property p_hw_wins;
    clk_en && push_go && wr_second |=> second_r == $past(page_r);
  endproperty
  a_hw_wins: assert property (p_hw_wins)
    else $error("software write beat a push");

  property p_rd_second;
    clk_en && sfr_rd && sfr_addr == spcs_pkg::ADDR_STACK_SECOND |=>
      sfr_rdata_valid && (sfr_rdata == $past(second_r));
  endproperty
  a_rd_second: assert property (p_rd_second)
    else $error("second entry read wrong");

  // the read itself never moves the entry; a push or write in the same cycle may
  property p_rd_third;
    clk_en && sfr_rd && sfr_addr == spcs_pkg::ADDR_STACK_THIRD |=>
      sfr_rdata_valid && (sfr_rdata == $past(third_r)) &&
      ($stable(third_r) || $past(push_go || wr_third));
  endproperty
  a_rd_third: assert property (p_rd_third)
    else $error("third entry read wrong or had a side effect");

  property p_rd_clean;
    s_quiet ##0 sfr_rd |=> $stable(page_r) && $stable(second_r);
  endproperty
  a_rd_clean: assert property (p_rd_clean)
    else $error("read disturbed the stack");

  // a pop leaves the bottom entry where it was
  property p_pop_third;
    s_pop_clean |=> $stable(third_r);
  endproperty
  a_pop_third: assert property (p_pop_third)
    else $error("pop changed the bottom entry");

  // two nested interrupts unwound in turn bring back the first page
  sequence s_nest_unwind;
    s_push ##1 s_push ##1 s_pop_clean ##1 s_pop_clean;
  endsequence

  property p_nest_unwind;
    s_nest_unwind |=> (page_r == $past(page_r, 4)) && (third_r == $past(page_r, 4));
  endproperty
  a_nest_unwind: assert property (p_nest_unwind)
    else $error("nested push and pop lost the first page");

  // the enable bit follows a write to the control register on its page
  property p_ctrl_wr;
    clk_en && wr_ctrl |=> auto_en_r == $past(sfr_wdata[spcs_pkg::BIT_AUTO_PAGING]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr)
    else $error("enable bit did not take the written value");

  // the control register is deaf while another page is selected
  property p_ctrl_off_page;
    clk_en && sfr_wr && sfr_addr == spcs_pkg::ADDR_PAGING_CTRL &&
      page_r != spcs_pkg::PAGE_PAGING_CTRL |=> $stable(auto_en_r);
  endproperty
  a_ctrl_off_page: assert property (p_ctrl_off_page)
    else $error("control write landed off its page");

  // the control byte reads back as reserved zeros over the enable bit
  property p_rd_ctrl;
    clk_en && sfr_rd && sfr_addr == spcs_pkg::ADDR_PAGING_CTRL &&
      page_r == spcs_pkg::PAGE_PAGING_CTRL |=>
      sfr_rdata_valid && (sfr_rdata == {spcs_pkg::CTRL_RSVD_READ, $past(auto_en_r)});
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control register read wrong");

  // page select reads back whatever page is live
  property p_rd_page;
    clk_en && sfr_rd && sfr_addr == spcs_pkg::ADDR_PAGE_SELECT |=>
      sfr_rdata_valid && (sfr_rdata == $past(page_r));
  endproperty
  a_rd_page: assert property (p_rd_page)
    else $error("page select read wrong");

  // addresses outside the block answer nothing, so no stale byte leaks out
  property p_rd_unmapped;
    clk_en && sfr_rd && sfr_addr != spcs_pkg::ADDR_PAGE_SELECT &&
      sfr_addr != spcs_pkg::ADDR_STACK_SECOND && sfr_addr != spcs_pkg::ADDR_STACK_THIRD &&
      sfr_addr != spcs_pkg::ADDR_PAGING_CTRL |=> !sfr_rdata_valid &&
      (sfr_rdata == spcs_pkg::DATA_ZERO);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read gave an answer");

  // a low clock enable freezes the stack, the enable bit and the read answer
  property p_ce_hold;
    !clk_en |=> $stable(page_r) && $stable(second_r) && $stable(third_r) &&
      $stable(auto_en_r) && $stable(sfr_rdata_valid);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("state moved while the clock enable was low");

endmodule

// ---- spcs_core_model.sv ----
/*
  Behavioural model of the processor core side: interrupt sequencer
  and register bus master, one operation per core_clk edge.
  Assumes the device samples strobes on the rising edge of core_clk.
*/
`timescale 1ns/1ps
module spcs_core_model (
  // clock
  input wire logic core_clk,
  // sequencer
  output logic clk_en,
  output logic irq_vector,
  output logic [7:0] irq_page,
  output logic irq_return,
  // register bus
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic sfr_rd,
  // device answers
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rdata_valid,
  input wire logic [7:0] page_select,
  input wire logic auto_paging_enable
);
  // idle bus at time zero
  initial begin
    clk_en = 1'b1;
    irq_vector = 1'b0;
    irq_page = 8'h00;
    irq_return = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
  end

  // drive one edge worth of requests, then sample what the previous edge left
  task automatic op(input logic ce, v, r, input logic [7:0] p, input logic w, rd,
                    input logic [7:0] a, d, output logic [7:0] rdat,
                    output logic vld, output logic [7:0] pg, output logic en);
    @(posedge core_clk);
    clk_en <= ce;
    irq_vector <= v;
    irq_return <= r;
    sfr_wr <= w;
    sfr_rd <= rd;
    // released fields flip so a stale value is never mistaken for a live one
    irq_page <= v ? p : ~irq_page;
    sfr_addr <= (w || rd) ? a : ~sfr_addr;
    sfr_wdata <= w ? d : ~sfr_wdata;
    #1;
    rdat = sfr_rdata;
    vld = sfr_rdata_valid;
    pg = page_select;
    en = auto_paging_enable;
  endtask
endmodule

// ---- tb_top.sv ----
/*
  Self-checking bench for the page context stack: directed corners
  followed by random traffic from an xorshift source.
  Assumes the core model drives all requests on the rising edge.
*/
`timescale 1ns/1ps
module tb_top;
  logic core_clk;
  logic rst_n;
  logic clk_en, irq_vector, irq_return, sfr_wr, sfr_rd, sfr_rdata_valid, auto_paging_enable;
  logic [7:0] irq_page, sfr_addr, sfr_wdata, sfr_rdata, page_select;
  logic [7:0] o_dat, o_pg, pv_dat;
  logic o_vld, o_en, pv_vld;
  logic [24:0] st;
  logic [31:0] seed;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  spcs_page_stack DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .irq_vector(irq_vector), .irq_page(irq_page), .irq_return(irq_return),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
    .page_select(page_select), .auto_paging_enable(auto_paging_enable));

  spcs_core_model u_core (.core_clk(core_clk), .clk_en(clk_en), .irq_vector(irq_vector),
    .irq_page(irq_page), .irq_return(irq_return), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_rdata_valid(sfr_rdata_valid), .page_select(page_select),
    .auto_paging_enable(auto_paging_enable));

  // 125 MHz core clock
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // state is {enable, page, second, third}; a push or pop beats a write
  function automatic logic [24:0] nxt(input logic [24:0] s, input logic ce, v, r,
                                      input logic [7:0] p, input logic w,
                                      input logic [7:0] a, d);
    logic en;
    logic [7:0] pg, sc, th;
    {en, pg, sc, th} = s;
    if (!ce) return s;
    if (en && v) begin
      th = sc;
      sc = pg;
      pg = p;
    end else if (en && r) begin
      pg = sc;
      sc = th;
    end else if (w) begin
      if (a == spcs_pkg::ADDR_PAGE_SELECT) pg = d;
      if (a == spcs_pkg::ADDR_STACK_SECOND) sc = d;
      if (a == spcs_pkg::ADDR_STACK_THIRD) th = d;
    end
    // the control byte is not a stack entry, so a shift never drops its write
    if (w && a == spcs_pkg::ADDR_PAGING_CTRL && s[23:16] == spcs_pkg::PAGE_PAGING_CTRL) begin
      en = d[spcs_pkg::BIT_AUTO_PAGING];
    end
    return {en, pg, sc, th};
  endfunction

  // read answer as {valid, data}; the control byte lives on one page only
  function automatic logic [8:0] rdx(input logic [24:0] s, input logic [7:0] a);
    if (a == spcs_pkg::ADDR_PAGE_SELECT) return {1'b1, s[23:16]};
    if (a == spcs_pkg::ADDR_STACK_SECOND) return {1'b1, s[15:8]};
    if (a == spcs_pkg::ADDR_STACK_THIRD) return {1'b1, s[7:0]};
    if (a == spcs_pkg::ADDR_PAGING_CTRL && s[23:16] == spcs_pkg::PAGE_PAGING_CTRL) begin
      return {1'b1, 7'h00, s[24]};
    end
    return 9'h000;
  endfunction

  // ----------------------------------------------------------------
  // checking and stimulus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // outputs seen now belong to the previous step, so expectations lag by one
  task automatic step(input logic ce, v, r, input logic [7:0] p, input logic w, rd,
                      input logic [7:0] a, d);
    logic [8:0] rx;
    u_core.op(ce, v, r, p, w, rd, a, d, o_dat, o_vld, o_pg, o_en);
    chk(o_pg, st[23:16]);
    chk({7'h00, o_en}, {7'h00, st[24]});
    chk({7'h00, o_vld}, {7'h00, pv_vld});
    if (pv_vld === 1'b1) chk(o_dat, pv_dat);
    rx = rdx(st, a);
    if (ce) begin
      pv_vld = rd & rx[8];
      pv_dat = rx[7:0];
    end
    st = nxt(st, ce, v, r, p, w, a, d);
  endtask

  task automatic wr(input logic [7:0] a, d);
    step(1'b1, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    step(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic push(input logic [7:0] p);
    step(1'b1, 1'b1, 1'b0, p, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic pop();
    step(1'b1, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h672e9798;
    st = {spcs_pkg::RST_AUTO_PAGING, spcs_pkg::RST_PAGE_SELECT,
          spcs_pkg::RST_STACK_SECOND, spcs_pkg::RST_STACK_THIRD};
    pv_vld = 1'b0;
    pv_dat = 8'h00;
    rst_n = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // reset contents, then the control byte off and on its page
    rd(8'h84);
    rd(8'h85);
    rd(8'h86);
    rd(8'h96);
    wr(8'h84, 8'h0f);
    rd(8'h96);
    // nested interrupts back to back after software seeded the stack
    wr(8'h85, 8'h11);
    wr(8'h86, 8'h22);
    push(8'h33);
    push(8'h44);
    rd(8'h85);
    rd(8'h86);
    pop();
    pop();
    // nested pair unwound with no gap between the events
    push(8'h71);
    push(8'h72);
    pop();
    pop();
    // hardware shifts beat writes in the same cycle; push beats pop
    step(1'b1, 1'b1, 1'b0, 8'h5a, 1'b1, 1'b0, 8'h85, 8'hc3);
    step(1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 8'h86, 8'h3c);
    step(1'b1, 1'b1, 1'b1, 8'h66, 1'b1, 1'b0, 8'h84, 8'h99);
    step(1'b0, 1'b1, 1'b0, 8'h77, 1'b0, 1'b0, 8'h00, 8'h00);
    // auto paging off: no page switch, no stack motion
    wr(8'h84, 8'h0f);
    wr(8'h96, 8'h00);
    push(8'h55);
    pop();
    rd(8'h96);
    wr(8'h96, 8'h01);
    wr(8'h87, 8'hff);
    rd(8'h87);
    // random traffic, including mixed strobes in one cycle
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      case (seed[2:0])
        3'h0: push(seed[15:8]);
        3'h1: pop();
        3'h2: wr(8'h84, seed[8] ? 8'h0f : seed[23:16]);
        3'h3: wr(8'h85, seed[23:16]);
        3'h4: wr(8'h86, seed[23:16]);
        3'h5: rd(8'h84 + {6'h00, seed[9:8]});
        3'h6: wr(8'h96, seed[23:16]);
        default: step(seed[9] | seed[3], seed[10], seed[11], seed[23:16], seed[12],
                      seed[13], 8'h84 + {6'h00, seed[15:14]}, seed[31:24]);
      endcase
    end
    rd(8'h85);
    step(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    finish_test();
  end
endmodule
